// ---- rtl/timer_pair_pkg.sv ----
// constants and types shared by the dual timer mode control block
// Functional notes
// - With its gate select set, timer one counts only while the external interrupt one pin is high and its run bit is set; otherwise the run bit alone decides.
// - With its gate select set, timer zero counts only while the external interrupt zero pin is high and its run bit is set; otherwise the run bit alone decides.
// - Timer one counts falling edges on its count pin when its counter select is set, and core clocks when it is clear.
// - Timer zero counts falling edges on its count pin when its counter select is set, and core clocks when it is clear.
// - In mode 00 the timer one high byte counts in eight bits behind a five-bit prescaler held in the low byte.
// - In mode 01 the two bytes of timer one form one 16-bit counter with no prescaler.
// - In mode 10 the timer one low byte counts and reloads from the high byte on overflow, and in mode 11 timer one stops.
// - In mode 00 the timer zero high byte counts in eight bits behind a five-bit prescaler held in the low byte.
// - In mode 01 the two bytes of timer zero form one 16-bit counter with no prescaler.
// - In mode 10 the timer zero low byte counts and reloads from the high byte each time it overflows.
// - In mode 11 the timer zero low byte is an 8-bit timer or counter under the timer zero gate, select and run bits.
// - In split mode the timer zero high byte is an 8-bit timer only, run by the timer one run bit.
// - A timer counts only while its run bit is set, and clearing the bit halts it; the split-mode timer zero high byte follows the timer one run bit instead.
// - A count pin event is a high sample followed by a low sample, and the source holds each level at least two cycles.
// - Each overflow sets the timer's overflow flag, but split mode gives timer one's flag to the timer zero high byte; the timer's vector acknowledge clears it.
// - In timer operation the low byte advances once per core clock.
package timer_pair_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_CTRL      = 8'h88;
    localparam logic [7:0] IDX_MODE      = 8'h89;
    localparam logic [7:0] IDX_TL0       = 8'h8a;
    localparam logic [7:0] IDX_TL1       = 8'h8b;
    localparam logic [7:0] IDX_TH0       = 8'h8c;
    localparam logic [7:0] IDX_TH1       = 8'h8d;
    localparam logic [7:0] IDX_IRQ_STAT  = 8'h90;
    localparam logic [7:0] IDX_IRQ_MASK  = 8'h91;

    // mode register fields
    localparam int MODE_TIMER_ONE_GATE_SELECT_BIT = 7;
    localparam int MODE_CT1_BIT   = 6;
    localparam int MODE_M1_LSB    = 4;
    localparam int MODE_TIMER_ZERO_GATE_SELECT_BIT = 3;
    localparam int MODE_CT0_BIT   = 2;
    localparam int MODE_M0_LSB    = 0;

    // control register fields
    localparam int CTRL_TF1_BIT = 7;
    localparam int CTRL_TR1_BIT = 6;
    localparam int CTRL_TF0_BIT = 5;
    localparam int CTRL_TR0_BIT = 4;

    // interrupt status and mask fields
    localparam int IRQ_T0_BIT = 0;
    localparam int IRQ_T1_BIT = 1;

    // reset values
    localparam logic [7:0] MODE_RESET     = 8'h00;
    localparam logic [7:0] COUNT_RESET    = 8'h00;
    localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
    localparam logic [4:0] PRESCALE_TOP   = 5'h1f;

    typedef enum logic [1:0] {
        MODE_PRESCALE = 2'h0,
        MODE_CASCADE  = 2'h1,
        MODE_RELOAD   = 2'h2,
        MODE_SPLIT    = 2'h3
    } timer_mode_e;

endpackage

// ---- rtl/pin_level_sync.sv ----
// three-stage pin synchroniser that accepts a level once two stages agree
`timescale 1ns/1ps
module pin_level_sync (
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    input  wire logic i_pin,
    output logic      o_level
);
    logic s1_r;
    logic s2_r;
    logic s3_r;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s1_r    <= 1'b0;
            s2_r    <= 1'b0;
            s3_r    <= 1'b0;
            o_level <= 1'b0;
        end else begin
            s1_r <= i_pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                o_level <= s2_r;
            end
        end
    end
endmodule

// ---- rtl/count_source.sv ----
// selects core clock or falling edges of a synchronised pin as count ticks
`timescale 1ns/1ps
module count_source (
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    input  wire logic i_level,
    input  wire logic i_counter_select,
    output logic      o_tick
);
    logic prev_r;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prev_r <= 1'b0;
        end else begin
            prev_r <= i_level;
        end
    end

    // high sample then low sample counts once
    assign o_tick = i_counter_select ? (prev_r & ~i_level) : 1'b1;
endmodule

// ---- rtl/dual_timer_mode_control.sv ----
// dual 16-bit timer/counter with mode control behind an APB slave
`timescale 1ns/1ps
module dual_timer_mode_control
    import timer_pair_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_resetn,
    input  wire logic [11:0] i_paddr,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    input  wire logic        i_ext_irq_zero_pin,
    input  wire logic        i_ext_irq_one_pin,
    input  wire logic        i_timer_zero_count_pin,
    input  wire logic        i_timer_one_count_pin,
    input  wire logic        i_timer_zero_vector_ack,
    input  wire logic        i_timer_one_vector_ack,
    output logic             o_timer_zero_overflow_flag,
    output logic             o_timer_one_overflow_flag,
    output logic             o_irq
);
    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    function automatic logic [8:0] inc8(input logic [7:0] v);
        inc8 = {1'b0, v} + 9'h001;
    endfunction

    // one step of a channel in modes 00..10; returns {ovf, th, tl}
    function automatic logic [16:0] step_pair(
        input logic [1:0] mode,
        input logic [7:0] tl,
        input logic [7:0] th
    );
        logic [8:0] lo;
        logic [8:0] hi;
        lo = inc8(tl);
        hi = inc8(th);
        step_pair = {1'b0, th, tl};
        case (mode)
            MODE_PRESCALE: begin
                if (tl[4:0] == PRESCALE_TOP) begin
                    step_pair = {hi[8], hi[7:0], tl[7:5], lo[4:0]};
                end else begin
                    step_pair = {1'b0, th, tl[7:5], lo[4:0]};
                end
            end
            MODE_CASCADE: begin
                if (lo[8]) begin
                    step_pair = {hi[8], hi[7:0], lo[7:0]};
                end else begin
                    step_pair = {1'b0, th, lo[7:0]};
                end
            end
            MODE_RELOAD: begin
                step_pair = {lo[8], th, (lo[8] ? th : lo[7:0])};
            end
            default: begin
                step_pair = {1'b0, th, tl};
            end
        endcase
    endfunction

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_s1_r;
    logic rst_n;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_s1_r <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n    <= rst_s1_r;
        end
    end

    // ------------------------------------------------------------
    // pin inputs
    // ------------------------------------------------------------
    logic int0_lvl;
    logic ext_irq_one_pin_lvl;
    logic cnt0_lvl;
    logic cnt1_lvl;
    logic tick0;
    logic tick1;

    logic [7:0]  mode_r;
    logic        tr0_r;
    logic        tr1_r;
    logic        tf0_r;
    logic        tf1_r;
    logic [7:0]  tl0_r;
    logic [7:0]  th0_r;
    logic [7:0]  tl1_r;
    logic [7:0]  th1_r;
    logic [1:0]  stat_r;
    logic [1:0]  mask_r;

    pin_level_sync u_sync_int0 (
        .i_clk   (i_clk),
        .i_rst_n (rst_n),
        .i_pin   (i_ext_irq_zero_pin),
        .o_level (int0_lvl)
    );
    pin_level_sync u_sync_ext_irq_one_pin (
        .i_clk   (i_clk),
        .i_rst_n (rst_n),
        .i_pin   (i_ext_irq_one_pin),
        .o_level (ext_irq_one_pin_lvl)
    );
    pin_level_sync u_sync_cnt0 (
        .i_clk   (i_clk),
        .i_rst_n (rst_n),
        .i_pin   (i_timer_zero_count_pin),
        .o_level (cnt0_lvl)
    );
    pin_level_sync u_sync_cnt1 (
        .i_clk   (i_clk),
        .i_rst_n (rst_n),
        .i_pin   (i_timer_one_count_pin),
        .o_level (cnt1_lvl)
    );
    count_source u_src0 (
        .i_clk            (i_clk),
        .i_rst_n          (rst_n),
        .i_level          (cnt0_lvl),
        .i_counter_select (mode_r[MODE_CT0_BIT]),
        .o_tick           (tick0)
    );
    count_source u_src1 (
        .i_clk            (i_clk),
        .i_rst_n          (rst_n),
        .i_level          (cnt1_lvl),
        .i_counter_select (mode_r[MODE_CT1_BIT]),
        .o_tick           (tick1)
    );

    // ------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------
    logic [7:0] idx;
    logic       addr_ok;
    logic       acc;
    logic       done;
    logic       wr_en;
    logic       rd_stat;
    logic [7:0] rd_val;
    logic       rd_hit;

    assign idx     = i_paddr[9:2];
    assign addr_ok = (i_paddr[1:0] == 2'h0) && (i_paddr[11:10] == 2'h0);
    assign acc     = i_psel & i_penable;
    assign done    = acc & o_pready;
    assign wr_en   = done & i_pwrite & ~o_pslverr;
    assign rd_stat = done & ~i_pwrite & addr_ok & (idx == IDX_IRQ_STAT);

    always_comb begin
        rd_val = 8'h00;
        rd_hit = addr_ok;
        if (!addr_ok) begin
            rd_hit = 1'b0;
        end else if (idx == IDX_CTRL) begin
            rd_val = {tf1_r, tr1_r, tf0_r, tr0_r, 4'h0};
        end else if (idx == IDX_MODE) begin
            rd_val = mode_r;
        end else if (idx == IDX_TL0) begin
            rd_val = tl0_r;
        end else if (idx == IDX_TL1) begin
            rd_val = tl1_r;
        end else if (idx == IDX_TH0) begin
            rd_val = th0_r;
        end else if (idx == IDX_TH1) begin
            rd_val = th1_r;
        end else if (idx == IDX_IRQ_STAT) begin
            rd_val = {6'h00, stat_r};
        end else if (idx == IDX_IRQ_MASK) begin
            rd_val = {6'h00, mask_r};
        end else begin
            rd_hit = 1'b0;
        end
    end

    // answer one cycle into the access phase, data latched with ready
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_pready  <= 1'b0;
            o_prdata  <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end else if (done) begin
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
        end else if (acc) begin
            o_pready  <= 1'b1;
            o_pslverr <= ~rd_hit;
            o_prdata  <= i_pwrite ? 32'h0000_0000 : {24'h00_0000, rd_val};
        end
    end

    logic wr_ctrl;
    logic wr_mode;
    logic wr_tl0;
    logic wr_th0;
    logic wr_tl1;
    logic wr_th1;
    logic wr_mask;

    assign wr_ctrl = wr_en & (idx == IDX_CTRL);
    assign wr_mode = wr_en & (idx == IDX_MODE);
    assign wr_tl0  = wr_en & (idx == IDX_TL0);
    assign wr_th0  = wr_en & (idx == IDX_TH0);
    assign wr_tl1  = wr_en & (idx == IDX_TL1);
    assign wr_th1  = wr_en & (idx == IDX_TH1);
    assign wr_mask = wr_en & (idx == IDX_IRQ_MASK);

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_r <= MODE_RESET;
        end else if (wr_mode) begin
            mode_r <= i_pwdata[7:0];
        end
    end

    // ------------------------------------------------------------
    // count enables and channel arithmetic
    // ------------------------------------------------------------
    timer_mode_e mode0;
    timer_mode_e mode1;
    logic        en0;
    logic        en1;
    logic        inc0;
    logic        inc1;
    logic        inc0h;
    logic [16:0] step0;
    logic [16:0] step1;
    logic [8:0]  split_lo;
    logic [8:0]  split_hi;
    logic [7:0]  tl0_nxt;
    logic [7:0]  th0_nxt;
    logic [7:0]  tl1_nxt;
    logic [7:0]  th1_nxt;
    logic        ovf0_evt;
    logic        ovf1_evt;
    logic        t1_ovf;
    logic        t0h_ovf;

    assign mode0 = timer_mode_e'(mode_r[MODE_M0_LSB +: 2]);
    assign mode1 = timer_mode_e'(mode_r[MODE_M1_LSB +: 2]);
    assign en0   = tr0_r & (~mode_r[MODE_TIMER_ZERO_GATE_SELECT_BIT] | int0_lvl);
    assign en1   = tr1_r & (~mode_r[MODE_TIMER_ONE_GATE_SELECT_BIT] | ext_irq_one_pin_lvl);
    assign inc0  = en0 & tick0;
    assign inc1  = en1 & tick1;
    // split high byte: timer only, run by the timer one run bit
    assign inc0h = tr1_r;

    assign step0    = step_pair(mode0, tl0_r, th0_r);
    assign step1    = step_pair(mode1, tl1_r, th1_r);
    assign split_lo = inc8(tl0_r);
    assign split_hi = inc8(th0_r);

    always_comb begin
        tl0_nxt  = tl0_r;
        th0_nxt  = th0_r;
        ovf0_evt = 1'b0;
        t0h_ovf  = 1'b0;
        if (mode0 == MODE_SPLIT) begin
            if (inc0) begin
                tl0_nxt  = split_lo[7:0];
                ovf0_evt = split_lo[8];
            end
            if (inc0h) begin
                th0_nxt = split_hi[7:0];
                t0h_ovf = split_hi[8];
            end
        end else if (inc0) begin
            {ovf0_evt, th0_nxt, tl0_nxt} = step0;
        end
    end

    always_comb begin
        tl1_nxt = tl1_r;
        th1_nxt = th1_r;
        t1_ovf  = 1'b0;
        if (inc1) begin
            {t1_ovf, th1_nxt, tl1_nxt} = step1;
        end
    end

    // split mode hands the timer one flag to the timer zero high byte
    assign ovf1_evt = (mode0 == MODE_SPLIT) ? t0h_ovf : t1_ovf;

    // software writes to a byte take priority over counting
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            tl0_r <= COUNT_RESET;
            th0_r <= COUNT_RESET;
        end else begin
            tl0_r <= wr_tl0 ? i_pwdata[7:0] : tl0_nxt;
            th0_r <= wr_th0 ? i_pwdata[7:0] : th0_nxt;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            tl1_r <= COUNT_RESET;
            th1_r <= COUNT_RESET;
        end else begin
            tl1_r <= wr_tl1 ? i_pwdata[7:0] : tl1_nxt;
            th1_r <= wr_th1 ? i_pwdata[7:0] : th1_nxt;
        end
    end

    // ------------------------------------------------------------
    // run bits and overflow flags
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            tr0_r <= 1'b0;
            tr1_r <= 1'b0;
        end else if (wr_ctrl) begin
            tr0_r <= i_pwdata[CTRL_TR0_BIT];
            tr1_r <= i_pwdata[CTRL_TR1_BIT];
        end
    end

    // an overflow in the clearing cycle wins
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            tf0_r <= 1'b0;
            tf1_r <= 1'b0;
        end else begin
            tf0_r <= ovf0_evt |
                     (wr_ctrl ? i_pwdata[CTRL_TF0_BIT] : (tf0_r & ~i_timer_zero_vector_ack));
            tf1_r <= ovf1_evt |
                     (wr_ctrl ? i_pwdata[CTRL_TF1_BIT] : (tf1_r & ~i_timer_one_vector_ack));
        end
    end

    assign o_timer_zero_overflow_flag = tf0_r;
    assign o_timer_one_overflow_flag  = tf1_r;

    // ------------------------------------------------------------
    // interrupt status, mask and output
    // ------------------------------------------------------------
    logic [1:0] evt;
    logic [1:0] stat_clr;

    assign evt[IRQ_T0_BIT] = ovf0_evt;
    assign evt[IRQ_T1_BIT] = ovf1_evt;
    // only the bits the read returned are cleared
    assign stat_clr        = rd_stat ? o_prdata[1:0] : 2'h0;

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            stat_r <= 2'h0;
        end else begin
            stat_r <= (stat_r & ~stat_clr) | evt;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_r <= IRQ_MASK_RESET;
        end else if (wr_mask) begin
            mask_r <= i_pwdata[1:0];
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(stat_r & mask_r);
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_gate_one_hold: assert property (@(posedge i_clk) disable iff (!rst_n)
        (mode_r[MODE_TIMER_ONE_GATE_SELECT_BIT] && !ext_irq_one_pin_lvl && !wr_tl1 && !wr_th1)
        |=> $stable({th1_r, tl1_r}))
        else $error("timer one counted with its gate closed");

    a_gate_zero_hold: assert property (@(posedge i_clk) disable iff (!rst_n)
        (mode_r[MODE_TIMER_ZERO_GATE_SELECT_BIT] && !int0_lvl && !wr_tl0)
        |=> $stable(tl0_r))
        else $error("timer zero low byte counted with its gate closed");

    a_run_zero_halt: assert property (@(posedge i_clk) disable iff (!rst_n)
        (!tr0_r && !wr_tl0) |=> $stable(tl0_r))
        else $error("timer zero low byte moved with run clear");

    a_timer_tick_rate: assert property (@(posedge i_clk) disable iff (!rst_n)
        (tr0_r && !mode_r[MODE_TIMER_ZERO_GATE_SELECT_BIT] && !mode_r[MODE_CT0_BIT] && mode0 == MODE_CASCADE
         && !wr_tl0 && !wr_ctrl && !wr_mode)
        |=> (tl0_r == 8'($past(tl0_r) + 8'h01)))
        else $error("timer zero did not advance once per clock");

    a_prescale_holds: assert property (@(posedge i_clk) disable iff (!rst_n)
        (mode1 == MODE_PRESCALE && tl1_r[4:0] != PRESCALE_TOP && !wr_th1)
        |=> $stable(th1_r))
        else $error("timer one high byte moved before prescaler wrap");

    a_reload_low: assert property (@(posedge i_clk) disable iff (!rst_n)
        (mode0 == MODE_RELOAD && inc0 && tl0_r == 8'hff && !wr_tl0)
        |=> (tl0_r == $past(th0_r)) && tf0_r)
        else $error("timer zero reload or flag missing");

    a_stop_one: assert property (@(posedge i_clk) disable iff (!rst_n)
        (mode1 == MODE_SPLIT && !wr_tl1 && !wr_th1) |=> $stable({th1_r, tl1_r}))
        else $error("timer one moved in stop mode");

    a_split_flag: assert property (@(posedge i_clk) disable iff (!rst_n)
        (mode0 == MODE_SPLIT && tr1_r && th0_r == 8'hff) |=> tf1_r ##1 stat_r[IRQ_T1_BIT])
        else $error("split high byte overflow did not reach timer one flag");

    a_count_edge: assert property (@(posedge i_clk) disable iff (!rst_n)
        (mode_r[MODE_CT0_BIT] && !cnt0_lvl && $past(!cnt0_lvl)) |-> !tick0)
        else $error("count tick without a falling pin edge");
endmodule

// ---- tb/pin_partner.sv ----
// pin-side model: count pins and interrupt gate pins
`timescale 1ns/1ps
module pin_partner (
    input  wire logic i_clk,
    output logic      o_count_pin_zero,
    output logic      o_count_pin_one,
    output logic      o_gate_zero,
    output logic      o_gate_one
);
    initial begin
        o_count_pin_zero = 1'b1;
        o_count_pin_one  = 1'b1;
        o_gate_zero      = 1'b0;
        o_gate_one       = 1'b0;
    end
    // n falling edges, each level held three cycles
    task automatic pulse(input int ch, input int n);
        for (int i = 0; i < 2 * n; i++) begin
            @(posedge i_clk);
            if (ch == 0) o_count_pin_zero <= i[0];
            else o_count_pin_one <= i[0];
            repeat (2) @(posedge i_clk);
        end
        repeat (8) @(posedge i_clk);
    endtask
    task automatic gate(input logic g0, input logic g1);
        @(posedge i_clk);
        o_gate_zero <= g0;
        o_gate_one  <= g1;
        repeat (8) @(posedge i_clk);
    endtask
endmodule

// ---- tb/tb.sv ----
// self-checking bench for the dual timer mode control block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin fails++; \
    $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module tb
    import timer_pair_pkg::*;
;
    logic        clk, resetn, psel, penable, pwrite, ack0, ack1, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        pready, pslverr, ovf0, ovf1, irq, cp0, cp1, g0, g1;
    logic [7:0]  q, a;
    int          fails = 0;
    int          checks = 0;

    dual_timer_mode_control DUT (
        .i_clk(clk), .i_resetn(resetn), .i_paddr(paddr), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_ext_irq_zero_pin(g0),
        .i_ext_irq_one_pin(g1), .i_timer_zero_count_pin(cp0), .i_timer_one_count_pin(cp1),
        .i_timer_zero_vector_ack(ack0), .i_timer_one_vector_ack(ack1),
        .o_timer_zero_overflow_flag(ovf0), .o_timer_one_overflow_flag(ovf1), .o_irq(irq));
    pin_partner PIN (.i_clk(clk), .o_count_pin_zero(cp0), .o_count_pin_one(cp1),
        .o_gate_zero(g0), .o_gate_one(g1));

    //------------------------------------------------------------
    // bus and check helpers
    //------------------------------------------------------------
    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {2'h0, idx, 2'h0};
        pwdata  <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        q = prdata[7:0];
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] idx, input logic [7:0] ex, input string nm);
        apb(1'b0, idx, 8'h00);
        `CHK(nm, ex, q)
    endtask
    task automatic cfg(input logic [7:0] md, l0, h0, l1, h1, ct);
        apb(1'b1, IDX_CTRL, 8'h00);
        apb(1'b1, IDX_MODE, md);
        apb(1'b1, IDX_TL0, l0);
        apb(1'b1, IDX_TH0, h0);
        apb(1'b1, IDX_TL1, l1);
        apb(1'b1, IDX_TH1, h1);
        apb(1'b1, IDX_CTRL, ct);
    endtask
    task automatic ack_both();
        @(posedge clk);
        ack0 <= 1'b1;
        ack1 <= 1'b1;
        @(posedge clk);
        ack0 <= 1'b0;
        ack1 <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    //------------------------------------------------------------
    // scenarios
    //------------------------------------------------------------
    task automatic t_reset();
        logic [7:0] ids [8] = '{IDX_CTRL, IDX_MODE, IDX_TL0, IDX_TL1, IDX_TH0, IDX_TH1,
                                IDX_IRQ_STAT, IDX_IRQ_MASK};
        foreach (ids[i]) rdchk(ids[i], 8'h00, "reset value");
        apb(1'b0, 8'h95, 8'h00);
        `CHK("unmapped error", 1'b1, e)
        apb(1'b1, IDX_MODE, 8'ha5);
        rdchk(IDX_MODE, 8'ha5, "mode readback");
        $display("test reset done");
    endtask
    task automatic t_rate();
        cfg(8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10);
        apb(1'b0, IDX_TL0, 8'h00);
        a = q;
        apb(1'b0, IDX_TL0, 8'h00);
        `CHK("timer rate", 8'h04, q - a)
        apb(1'b1, IDX_CTRL, 8'h00);
        apb(1'b0, IDX_TL0, 8'h00);
        a = q;
        repeat (10) @(posedge clk);
        rdchk(IDX_TL0, a, "halted");
        $display("test rate done");
    endtask
    task automatic t_count();
        cfg(8'h05, 8'hfe, 8'h00, 8'h00, 8'h00, 8'h10);
        PIN.pulse(0, 3);
        rdchk(IDX_TL0, 8'h01, "cascade low");
        rdchk(IDX_TH0, 8'h01, "cascade high");
        cfg(8'h40, 8'h00, 8'h00, 8'hfe, 8'hff, 8'h40);
        PIN.pulse(1, 2);
        rdchk(IDX_TL1, 8'he0, "prescale low");
        rdchk(IDX_TH1, 8'h00, "prescale high");
        rdchk(IDX_CTRL, 8'hc0, "flag one set");
        ack_both();
        `CHK("flag one ack", 1'b0, ovf1)
        $display("test count done");
    endtask
    task automatic t_reload();
        cfg(8'h66, 8'hff, 8'h80, 8'hff, 8'h33, 8'h50);
        PIN.pulse(0, 1);
        PIN.pulse(1, 1);
        rdchk(IDX_TL0, 8'h80, "reload zero");
        rdchk(IDX_TL1, 8'h33, "reload one");
        `CHK("flag zero", 1'b1, ovf0)
        apb(1'b1, IDX_MODE, 8'h76);
        PIN.pulse(1, 2);
        rdchk(IDX_TL1, 8'h33, "stopped one");
        ack_both();
        `CHK("flag zero ack", 1'b0, ovf0)
        $display("test reload done");
    endtask
    task automatic t_gate();
        cfg(8'hdd, 8'h00, 8'h00, 8'hff, 8'h00, 8'h50);
        PIN.pulse(0, 2);
        PIN.pulse(1, 2);
        rdchk(IDX_TL0, 8'h00, "gated zero");
        rdchk(IDX_TL1, 8'hff, "gated one");
        PIN.gate(1'b1, 1'b1);
        PIN.pulse(0, 2);
        PIN.pulse(1, 2);
        rdchk(IDX_TL0, 8'h02, "open zero");
        rdchk(IDX_TL1, 8'h01, "open one");
        rdchk(IDX_TH1, 8'h01, "cascade one high");
        PIN.gate(1'b0, 1'b0);
        $display("test gate done");
    endtask
    task automatic t_split();
        cfg(8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40);
        apb(1'b0, IDX_IRQ_STAT, 8'h00);
        apb(1'b0, IDX_TH0, 8'h00);
        a = q;
        apb(1'b0, IDX_TH0, 8'h00);
        `CHK("split high rate", 8'h04, q - a)
        PIN.pulse(0, 2);
        rdchk(IDX_TL0, 8'h00, "split low idle");
        apb(1'b1, IDX_CTRL, 8'h50);
        PIN.pulse(0, 2);
        rdchk(IDX_TL0, 8'h02, "split low count");
        apb(1'b1, IDX_TH0, 8'hf0);
        repeat (20) @(posedge clk);
        `CHK("split flag one", 1'b1, ovf1)
        apb(1'b1, IDX_CTRL, 8'h00);
        apb(1'b1, IDX_IRQ_MASK, 8'h00);
        repeat (2) @(posedge clk);
        `CHK("irq masked", 1'b0, irq)
        apb(1'b1, IDX_IRQ_MASK, 8'h02);
        repeat (2) @(posedge clk);
        `CHK("irq raised", 1'b1, irq)
        rdchk(IDX_IRQ_STAT, 8'h02, "status");
        repeat (2) @(posedge clk);
        `CHK("irq cleared", 1'b0, irq)
        $display("test split done");
    endtask

    //------------------------------------------------------------
    // run control
    //------------------------------------------------------------
    task automatic report_and_stop();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        repeat (30000) @(posedge clk);
        fails++;
        report_and_stop();
    end
    initial begin
        resetn  = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0;
        ack0    = 1'b0;
        ack1    = 1'b0;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        repeat (8) @(posedge clk);
        t_reset();
        t_rate();
        t_count();
        t_reload();
        t_gate();
        t_split();
        report_and_stop();
    end
endmodule
